// File: rtl/coeff_nvm_pkg.sv
// constants, types and helpers for the coefficient / nonvolatile store block
// assumes a single clock domain and a 32-bit register bus with word-aligned registers
`default_nettype none
package coeff_nvm_pkg;
    // register indices; the byte address is four times the index
    localparam logic [5:0] IDX_OFFQ = 6'h0f;
    localparam logic [5:0] IDX_PWRQ = 6'h10;
    localparam logic [5:0] IDX_TCA = 6'h11;
    localparam logic [5:0] IDX_TCB = 6'h12;
    localparam logic [5:0] IDX_MAKER = 6'h1e;
    localparam logic [5:0] IDX_PART = 6'h1f;
    localparam logic [5:0] IDX_CMD = 6'h2a;
    // reset values
    localparam logic [15:0] RST_OFFQ = 16'h0553;
    localparam logic [15:0] RST_PWRQ = 16'h0000;
    localparam logic [15:0] RST_TCA = 16'h0034;
    localparam logic [15:0] RST_TCB = 16'h0000;
    localparam logic [15:0] RST_CMD = 16'h0000;
    // power quadratic coefficient keeps bits 15..4 only
    localparam logic [15:0] PWRQ_MASK = 16'hfff0;
    // command register fields
    localparam logic [7:0] NVM_KEY = 8'h6a;
    localparam int KEY_LSB = 8;
    localparam int CNT_LSB = 13;
    localparam int CRPT_BIT = 12;
    localparam int ADR_LSB = 3;
    localparam int GLOAD_BIT = 2;
    localparam int STORE_BIT = 1;
    localparam int SLOAD_BIT = 0;
    // programming limit per location
    localparam logic [3:0] PROG_MAX = 4'h8;
    localparam logic [2:0] CNT_SHOWN_MAX = 3'h7;
    localparam int NSLOT = 4;

    // decoded command write
    typedef struct packed {
        logic key_ok;
        logic gload;
        logic store;
        logic sload;
        logic [4:0] adr;
    } cmd_t;

    // whole state of the block
    typedef struct packed {
        logic [NSLOT-1:0][15:0] coeff;
        logic [NSLOT-1:0][15:0] nvm;
        logic [NSLOT-1:0][3:0] pcount;
        logic [4:0] adr;
        logic ack;
        logic [31:0] rdata;
    } state_t;

    // maps a register index to {valid, slot}
    function automatic logic [2:0] slot_of(input logic [5:0] idx);
        logic [5:0] d;
        d = idx - IDX_OFFQ;
        slot_of = {(idx >= IDX_OFFQ) && (idx <= IDX_TCB), d[1:0]};
    endfunction
endpackage
`default_nettype wire

// File: rtl/coeff_nvm_store_load.sv
// coefficient registers, identification registers and nonvolatile store/load command
// assumes Avalon-MM slave access on clk and a same-clock status corruption bit
//
// Local design decision: the Avalon-MM interface to the registers.
`default_nettype none
// What this block does
// - offset quadratic coefficient is a 16-bit signed read/write register
// - offset quadratic coefficient sits at index 0fh, resets to 0553h
// - power quadratic coefficient keeps 12 bits in 15..4, low bits unused
// - power quadratic coefficient sits at index 10h, resets to zero
// - first transient coefficient at index 11h, read/write, resets to 0034h
// - second transient coefficient at index 12h, read/write, resets to zero
// - transient reset values suit the default four-average conversion mode
// - maker code at index 1eh is fixed and ignores writes
// - index 1fh reads part code in 15..4 and revision in 3..0
// - command register at index 2ah reads zero after reset, bar bit 12 which mirrors the corruption bit
// - command read gives count, corruption flag, address, zeros in 2..0
// - a location takes at most eight stores, later stores ignored
// - command bit 12 always mirrors status corruption bit
// - address field uses normal register numbering to pick the target
// - keyed general load reloads all four coefficient registers from their stored values
// - keyed store copies the addressed register into its location
// - keyed single load restores only the addressed register
module coeff_nvm_store_load
    import coeff_nvm_pkg::*;
#(
    parameter logic [15:0] MAKER_CODE = 16'h1234, // arbitrary value
    parameter logic [11:0] PART_CODE = 12'h0ab, // arbitrary value
    parameter logic [3:0] REVISION_CODE = 4'h1 // arbitrary value
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic mem_corrupt,
    output logic [15:0] offset_quadratic_coeff,
    output logic [15:0] power_quadratic_coeff,
    output logic [15:0] transient_coeff_first,
    output logic [15:0] transient_coeff_second
);
    state_t s_r;
    state_t s_nxt;
    cmd_t cmd;
    logic req;
    logic aligned;
    logic [5:0] idx;
    logic [2:0] wslot;
    logic [2:0] tslot;
    logic [2:0] rslot;
    logic wr_acc;
    logic rd_acc;
    logic cmd_hit;
    logic [31:0] rd_val;
    logic [2:0] cnt_shown;

    // bus decode; a request is held by the master until waitrequest drops,
    // so every access costs one wait cycle and is accepted on the edge after it
    // registers sit on word boundaries; any other byte address reads as unmapped
    // and a write there is ignored
    assign req = avs_read || avs_write;
    assign aligned = (avs_address[1:0] == 2'b00);
    assign idx = avs_address[7:2];
    assign wslot = slot_of(idx);
    assign wr_acc = avs_write && s_r.ack;
    assign rd_acc = avs_read && s_r.ack;
    assign cmd_hit = wr_acc && aligned && (idx == IDX_CMD) && (avs_byteenable[1:0] == 2'b11);

    // command fields, only meaningful with the key in the upper byte
    // the fields are decoded for every write, but only a keyed write to the
    // command index with both low lanes lets them act
    always_comb begin
        cmd.key_ok = (avs_writedata[KEY_LSB+:8] == NVM_KEY);
        cmd.gload = avs_writedata[GLOAD_BIT];
        cmd.store = avs_writedata[STORE_BIT];
        cmd.sload = avs_writedata[SLOAD_BIT];
        cmd.adr = avs_writedata[ADR_LSB+:5];
    end
    assign tslot = slot_of({1'b0, cmd.adr});

    // count shown for the location picked by the held address
    // the internal count runs to eight, the field is three bits wide,
    // so a used-up location reads as seven; other indices read zero
    assign rslot = slot_of({1'b0, s_r.adr});
    always_comb begin
        cnt_shown = 3'h0;
        if (rslot[2]) begin
            if (s_r.pcount[rslot[1:0]] >= PROG_MAX) begin
                cnt_shown = CNT_SHOWN_MAX;
            end else begin
                cnt_shown = s_r.pcount[rslot[1:0]][2:0];
            end
        end
    end

    // read multiplexer; unmapped indices read zero
    // the word is captured in the wait cycle, so the value shown is the one
    // from the cycle before the accepting edge, which is stable for a held request
    always_comb begin
        rd_val = 32'h0000_0000;
        if (aligned) begin
            case (idx)
                IDX_OFFQ, IDX_PWRQ, IDX_TCA, IDX_TCB: begin
                    rd_val[15:0] = s_r.coeff[wslot[1:0]];
                end
                IDX_MAKER: begin
                    rd_val[15:0] = MAKER_CODE;
                end
                IDX_PART: begin
                    rd_val[15:0] = {PART_CODE, REVISION_CODE};
                end
                IDX_CMD: begin
                    rd_val[CNT_LSB+:3] = cnt_shown;
                    rd_val[CRPT_BIT] = mem_corrupt;
                    rd_val[ADR_LSB+:5] = s_r.adr;
                    rd_val[2:0] = 3'h0;
                end
                default: begin
                    rd_val = 32'h0000_0000;
                end
            endcase
        end
    end

    // next state: bus handshake, register writes, store and load commands
    // a store copies the register as it stood before this write, and loads use
    // stored values from before it, so a combined store and load is well defined;
    // a general load wins over a single load
    always_comb begin
        s_nxt = s_r;
        s_nxt.ack = req && !s_r.ack;
        if (avs_read && !s_r.ack) begin
            s_nxt.rdata = rd_val;
        end
        // plain coefficient writes by byte lane
        if (wr_acc && aligned && wslot[2]) begin
            for (int b = 0; b < 2; b++) begin
                if (avs_byteenable[b]) begin
                    s_nxt.coeff[wslot[1:0]][8*b+:8] = avs_writedata[8*b+:8];
                end
            end
            if (idx == IDX_PWRQ) begin
                s_nxt.coeff[1] = s_nxt.coeff[1] & PWRQ_MASK;
            end
        end
        // keyed command; without the key nothing changes
        // the strobes are taken straight from the write data and never held,
        // so each accepted write acts exactly once and nothing reads back as one
        if (cmd_hit && cmd.key_ok) begin
            s_nxt.adr = cmd.adr;
            if (cmd.store && tslot[2] && (s_r.pcount[tslot[1:0]] < PROG_MAX)) begin
                s_nxt.nvm[tslot[1:0]] = s_r.coeff[tslot[1:0]];
                s_nxt.pcount[tslot[1:0]] = s_r.pcount[tslot[1:0]] + 4'h1;
            end
            if (cmd.gload) begin
                s_nxt.coeff = s_r.nvm;
            end else if (cmd.sload && tslot[2]) begin
                s_nxt.coeff[tslot[1:0]] = s_r.nvm[tslot[1:0]];
            end
        end
    end

    // state register; stored values start as the reset defaults
    // the stored copies are modelled as volatile here: reset brings them back
    // to the defaults, and a user who needs real retention must keep them
    // outside this block
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_r.coeff <= {RST_TCB, RST_TCA, RST_PWRQ, RST_OFFQ};
            s_r.nvm <= {RST_TCB, RST_TCA, RST_PWRQ, RST_OFFQ};
            s_r.pcount <= '0;
            s_r.adr <= RST_CMD[ADR_LSB+:5];
            s_r.ack <= 1'b0;
            s_r.rdata <= 32'h0000_0000;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs
    // waitrequest is combinational so the first cycle of a request stalls at once;
    // the coefficient outputs come straight from the state register
    assign avs_waitrequest = req && !s_r.ack;
    assign avs_readdata = s_r.rdata;
    assign offset_quadratic_coeff = s_r.coeff[0];
    assign power_quadratic_coeff = s_r.coeff[1];
    assign transient_coeff_first = s_r.coeff[2];
    assign transient_coeff_second = s_r.coeff[3];

    // checks on the bus handshake, the registers and the store/load command;
    // all run on clk and are switched off while reset is low

    // every request is answered one cycle after it is first seen
    wait_one_a: assert property (@(posedge clk) disable iff (!reset_n)
        (req && avs_waitrequest) |=> !avs_waitrequest)
        else $error("request not answered after one wait cycle");

    // coefficients come up at their defaults after reset
    reset_vals_a: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(reset_n) |-> (s_r.coeff[0] == RST_OFFQ) && (s_r.coeff[2] == RST_TCA)
            && (s_r.coeff[1] == RST_PWRQ) && (s_r.coeff[3] == RST_TCB))
        else $error("coefficient reset value wrong");

    // unused low bits of the power coefficient stay zero
    pwrq_low_a: assert property (@(posedge clk) disable iff (!reset_n)
        s_r.coeff[1][3:0] == 4'h0)
        else $error("power coefficient low bits not zero");

    // maker code read returns the fixed value
    maker_read_a: assert property (@(posedge clk) disable iff (!reset_n)
        (rd_acc && aligned && (idx == IDX_MAKER)) |-> (avs_readdata[15:0] == MAKER_CODE))
        else $error("maker code read wrong");

    // part and revision read back in their fields
    part_read_a: assert property (@(posedge clk) disable iff (!reset_n)
        (rd_acc && aligned && (idx == IDX_PART)) |-> (avs_readdata == {16'h0000, PART_CODE, REVISION_CODE}))
        else $error("part code read wrong");

    // command read mirrors the corruption bit and hides the strobes
    cmd_mirror_a: assert property (@(posedge clk) disable iff (!reset_n)
        (rd_acc && aligned && (idx == IDX_CMD)) |->
            (avs_readdata[CRPT_BIT] == $past(mem_corrupt)) && (avs_readdata[2:0] == 3'h0)
            && (avs_readdata[ADR_LSB+:5] == s_r.adr))
        else $error("command read fields wrong");

    // a command write without the key leaves stored and live values untouched
    key_guard_a: assert property (@(posedge clk) disable iff (!reset_n)
        (cmd_hit && !cmd.key_ok) |=> $stable(s_r.nvm) && $stable(s_r.pcount) && $stable(s_r.coeff)
            && $stable(s_r.adr))
        else $error("unkeyed command changed state");

    // a store below the limit adds exactly one to the count
    store_count_a: assert property (@(posedge clk) disable iff (!reset_n)
        (cmd_hit && cmd.key_ok && cmd.store && tslot[2] && (s_r.pcount[tslot[1:0]] < PROG_MAX))
            |=> (s_r.pcount[$past(tslot[1:0])] == $past(s_r.pcount[tslot[1:0]]) + 4'h1)
            && (s_r.nvm[$past(tslot[1:0])] == $past(s_r.coeff[tslot[1:0]])))
        else $error("store did not copy and count");

    // after eight stores the location no longer changes
    store_limit_a: assert property (@(posedge clk) disable iff (!reset_n)
        (cmd_hit && cmd.key_ok && cmd.store && tslot[2] && (s_r.pcount[tslot[1:0]] == PROG_MAX))
            |=> $stable(s_r.nvm) && $stable(s_r.pcount))
        else $error("store accepted past the limit");

    // single load restores the addressed coefficient from its stored value
    single_load_a: assert property (@(posedge clk) disable iff (!reset_n)
        (cmd_hit && cmd.key_ok && cmd.sload && !cmd.gload && tslot[2])
            |=> (s_r.coeff[$past(tslot[1:0])] == $past(s_r.nvm[tslot[1:0]])))
        else $error("single load wrong");

    // general load restores every coefficient
    general_load_a: assert property (@(posedge clk) disable iff (!reset_n)
        (cmd_hit && cmd.key_ok && cmd.gload) |=> (s_r.coeff == $past(s_r.nvm)))
        else $error("general load wrong");

    // counts never pass the limit
    count_bound_a: assert property (@(posedge clk) disable iff (!reset_n)
        (s_r.pcount[0] <= PROG_MAX) && (s_r.pcount[1] <= PROG_MAX)
            && (s_r.pcount[2] <= PROG_MAX) && (s_r.pcount[3] <= PROG_MAX))
        else $error("program count past limit");

    // an accepted request is never accepted again on the next edge, so strobes act once
    one_accept_a: assert property (@(posedge clk) disable iff (!reset_n)
        (wr_acc || rd_acc) |=> !(wr_acc || rd_acc))
        else $error("request accepted twice in a row");

    // only the low half of the read word carries register bits
    upper_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
        rd_acc |-> (avs_readdata[31:16] == 16'h0000))
        else $error("upper half of read word not zero");

    // a full-width write to a plain coefficient lands unchanged
    coeff_write_a: assert property (@(posedge clk) disable iff (!reset_n)
        (wr_acc && aligned && wslot[2] && (idx != IDX_PWRQ) && (avs_byteenable[1:0] == 2'b11))
            |=> (s_r.coeff[$past(wslot[1:0])] == $past(avs_writedata[15:0])))
        else $error("coefficient write lost");

    // a write to the power coefficient keeps bits 15..4 and drops the rest
    pwrq_write_a: assert property (@(posedge clk) disable iff (!reset_n)
        (wr_acc && aligned && (idx == IDX_PWRQ) && (avs_byteenable[1:0] == 2'b11))
            |=> (s_r.coeff[1] == ($past(avs_writedata[15:0]) & PWRQ_MASK)))
        else $error("power coefficient write wrong");

    // a write on the upper lane alone keeps the lower byte
    lane_keep_a: assert property (@(posedge clk) disable iff (!reset_n)
        (wr_acc && aligned && wslot[2] && (avs_byteenable[1:0] == 2'b10))
            |=> (s_r.coeff[$past(wslot[1:0])][7:0] == $past(s_r.coeff[wslot[1:0]][7:0]))
            && (s_r.coeff[$past(wslot[1:0])][15:8] == $past(avs_writedata[15:8])))
        else $error("byte lane write wrong");

    // a coefficient read returns the live register
    coeff_read_a: assert property (@(posedge clk) disable iff (!reset_n)
        (rd_acc && aligned && wslot[2]) |-> (avs_readdata[15:0] == s_r.coeff[wslot[1:0]]))
        else $error("coefficient read wrong");

    // writes to the identification registers change no state
    ro_write_a: assert property (@(posedge clk) disable iff (!reset_n)
        (wr_acc && aligned && ((idx == IDX_MAKER) || (idx == IDX_PART)))
            |=> $stable(s_r.coeff) && $stable(s_r.nvm) && $stable(s_r.pcount) && $stable(s_r.adr))
        else $error("write to identification register changed state");

    // a command write that misses a low lane is dropped whole
    lane_cmd_a: assert property (@(posedge clk) disable iff (!reset_n)
        (wr_acc && aligned && (idx == IDX_CMD) && (avs_byteenable[1:0] != 2'b11))
            |=> $stable(s_r.adr) && $stable(s_r.nvm) && $stable(s_r.pcount) && $stable(s_r.coeff))
        else $error("partial command write acted");

    // every keyed command write latches its address field
    addr_latch_a: assert property (@(posedge clk) disable iff (!reset_n)
        (cmd_hit && cmd.key_ok) |=> (s_r.adr == $past(cmd.adr)))
        else $error("command address not latched");

    // stored values change only under a keyed store
    nvm_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        !(cmd_hit && cmd.key_ok && cmd.store) |=> $stable(s_r.nvm))
        else $error("stored value changed without a store");

    // live coefficients change only at an accepted write
    coeff_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        !wr_acc |=> $stable(s_r.coeff))
        else $error("coefficient changed without a write");

    // program counts move only under a keyed store
    count_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        !(cmd_hit && cmd.key_ok && cmd.store) |=> $stable(s_r.pcount))
        else $error("program count changed without a store");

    // a store naming an index without a stored location does nothing
    bad_target_a: assert property (@(posedge clk) disable iff (!reset_n)
        (cmd_hit && cmd.key_ok && cmd.store && !tslot[2])
            |=> $stable(s_r.nvm) && $stable(s_r.pcount))
        else $error("store to an index without a location acted");

    // the count field shows seven once a location is used up
    cnt_sat_a: assert property (@(posedge clk) disable iff (!reset_n)
        (rd_acc && aligned && (idx == IDX_CMD) && rslot[2] && (s_r.pcount[rslot[1:0]] == PROG_MAX))
            |-> (avs_readdata[CNT_LSB+:3] == CNT_SHOWN_MAX))
        else $error("used-up count not shown as seven");

    // an address without a location shows a zero count
    cnt_none_a: assert property (@(posedge clk) disable iff (!reset_n)
        (rd_acc && aligned && (idx == IDX_CMD) && !rslot[2]) |-> (avs_readdata[CNT_LSB+:3] == 3'h0))
        else $error("count shown for an address without a location");

    // misaligned reads come back as zero
    rd_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
        (rd_acc && !aligned) |-> (avs_readdata == 32'h0000_0000))
        else $error("misaligned read not zero");

    // after reset the command register, counts and read word start clear
    reset_cmd_a: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(reset_n) |-> (s_r.adr == 5'h00) && (s_r.pcount == '0)
            && (avs_readdata == 32'h0000_0000))
        else $error("command state not clear after reset");

    // stored values start from the coefficient defaults
    nvm_reset_a: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(reset_n) |-> (s_r.nvm == {RST_TCB, RST_TCA, RST_PWRQ, RST_OFFQ}))
        else $error("stored value reset wrong");

    // a single load of the offset coefficient leaves the other three alone
    sload_others_a: assert property (@(posedge clk) disable iff (!reset_n)
        (cmd_hit && cmd.key_ok && cmd.sload && !cmd.gload && (tslot == 3'b100))
            |=> (s_r.coeff[3:1] == $past(s_r.coeff[3:1])))
        else $error("single load touched another coefficient");

    // read data stands until the next read's wait cycle
    rdata_stand_a: assert property (@(posedge clk) disable iff (!reset_n)
        !(avs_read && !s_r.ack) |=> $stable(avs_readdata))
        else $error("read data changed without a read");
endmodule // coeff_nvm_store_load
`default_nettype wire

// File: sim/coeff_nvm_store_load_tb.sv
// self-checking bench for the coefficient registers and the nonvolatile store/load command
// assumes the block answers each bus request on its own and has no other clock than clk
`default_nettype none
module coeff_nvm_store_load_tb import coeff_nvm_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] MAKER = 16'h2c5d; // arbitrary value
    localparam logic [11:0] PART = 12'h3e7; // arbitrary value
    localparam logic [3:0] REV = 4'h2; // arbitrary value
    typedef struct packed {
        logic wr;
        logic [5:0] idx;
        logic [15:0] wd;
        logic [15:0] exp;
    } row_t;
    // ordinary cases: reset values, plain read/write, read-only places
    localparam row_t ROWS [13] = '{
        '{1'b0, IDX_OFFQ, 16'h0, 16'h0553},
        '{1'b0, IDX_PWRQ, 16'h0, 16'h0000},
        '{1'b0, IDX_TCA, 16'h0, 16'h0034},
        '{1'b0, IDX_TCB, 16'h0, 16'h0000},
        '{1'b0, IDX_CMD, 16'h0, 16'h0000},
        '{1'b1, IDX_OFFQ, 16'h8001, 16'h0},
        '{1'b1, IDX_PWRQ, 16'habcd, 16'h0},
        '{1'b1, IDX_TCA, 16'h1234, 16'h0},
        '{1'b1, IDX_TCB, 16'hfedc, 16'h0},
        '{1'b1, IDX_MAKER, 16'h0000, 16'h0},
        '{1'b1, IDX_PART, 16'hffff, 16'h0},
        '{1'b0, IDX_MAKER, 16'h0, MAKER},
        '{1'b0, IDX_PART, 16'h0, {PART, REV}}
    };
    logic clk, reset_n, avs_read, avs_write, avs_waitrequest, mem_corrupt;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [3:0] avs_byteenable;
    logic [15:0] offq, pwrq, tca, tcb;
    int err_count, samples_checked;

    coeff_nvm_store_load #(.MAKER_CODE(MAKER), .PART_CODE(PART), .REVISION_CODE(REV)) u_coeff_nvm_store_load (
        .clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mem_corrupt(mem_corrupt),
        .offset_quadratic_coeff(offq), .power_quadratic_coeff(pwrq),
        .transient_coeff_first(tca), .transient_coeff_second(tcb));

    // 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one bus transfer, held until waitrequest is seen low at a rising edge
    task automatic xfer(input logic wr, input logic [7:0] adr, input logic [15:0] wd, input logic [3:0] be);
        int n;
        @(posedge clk);
        avs_address <= adr;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {~wd, wd};
        avs_byteenable <= be;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 16);
        if (avs_waitrequest !== 1'b0) begin
            err_count++;
            $display("wrong value waitrequest expected 0 seen %b", avs_waitrequest);
            tally_and_finish();
        end else begin
            rd = avs_readdata;
            avs_write <= 1'b0;
            avs_read <= 1'b0;
        end
    endtask

    task automatic wreg(input logic [5:0] idx, input logic [15:0] wd);
        xfer(1'b1, {idx, 2'b00}, wd, 4'hf);
    endtask

    task automatic rchk(input logic [5:0] idx, input logic [15:0] exp);
        xfer(1'b0, {idx, 2'b00}, 16'h0, 4'hf);
        check("register read", {16'h0, exp}, rd);
    endtask

    // coefficient outputs, looked at away from the clock edge
    task automatic port_chk(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c, input logic [15:0] d);
        @(negedge clk);
        check("offset port", {16'h0, a}, {16'h0, offq});
        check("power port", {16'h0, b}, {16'h0, pwrq});
        check("first transient port", {16'h0, c}, {16'h0, tca});
        check("second transient port", {16'h0, d}, {16'h0, tcb});
        @(posedge clk);
    endtask

    // main sequence
    initial begin
        reset_n = 1'b0;
        avs_address = 8'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        mem_corrupt = 1'b0;
        err_count = 0;
        samples_checked = 0;
        repeat (5) @(posedge clk);
        port_chk(16'h0553, 16'h0000, 16'h0034, 16'h0000);
        reset_n <= 1'b1;
        foreach (ROWS[i]) begin
            xfer(ROWS[i].wr, {ROWS[i].idx, 2'b00}, ROWS[i].wd, 4'hf);
            if (!ROWS[i].wr) check("table read", {16'h0, ROWS[i].exp}, rd);
        end
        rchk(IDX_PWRQ, 16'habc0);
        // store, overwrite, unkeyed store, single load, general load
        wreg(IDX_CMD, 16'h6a7a);
        rchk(IDX_CMD, 16'h2078);
        wreg(IDX_OFFQ, 16'h1111);
        wreg(IDX_CMD, 16'h557a);
        wreg(IDX_TCA, 16'h5555);
        wreg(IDX_CMD, 16'h6a79);
        rchk(IDX_OFFQ, 16'h8001);
        rchk(IDX_TCA, 16'h5555);
        wreg(IDX_CMD, 16'h6a04);
        port_chk(16'h8001, 16'h0000, 16'h0034, 16'h0000);
        // nine stores to one location, the last one refused; flag mirrored
        for (int i = 0; i < 9; i++) begin
            mem_corrupt <= i[0];
            wreg(IDX_TCB, 16'h0100 + 16'(i));
            wreg(IDX_CMD, 16'h6a92);
            rchk(IDX_CMD, {((i < 7) ? 3'(i + 1) : 3'h7), i[0], 12'h090});
        end
        wreg(IDX_CMD, 16'h6a91);
        rchk(IDX_TCB, 16'h0107);
        // partial byte lanes, unmapped places
        xfer(1'b1, {IDX_CMD, 2'b00}, 16'h6a8a, 4'h1);
        rchk(IDX_CMD, 16'he090);
        wreg(IDX_CMD, 16'h6af2);
        rchk(IDX_CMD, 16'h00f0);
        xfer(1'b1, {IDX_TCA, 2'b00}, 16'habcd, 4'h2);
        rchk(IDX_TCA, 16'hab34);
        xfer(1'b0, {IDX_OFFQ, 2'b01}, 16'h0, 4'hf);
        check("misaligned read", 32'h0, rd);
        xfer(1'b0, 8'h80, 16'h0, 4'hf);
        check("unmapped read", 32'h0, rd);
        // second reset in mid-run
        @(posedge clk);
        reset_n <= 1'b0;
        port_chk(16'h0553, 16'h0000, 16'h0034, 16'h0000);
        reset_n <= 1'b1;
        rchk(IDX_CMD, 16'h0000);
        tally_and_finish();
    end
endmodule // coeff_nvm_store_load_tb
`default_nettype wire
